// ===== ciolep_defines.vh
// Constants for the camera I/O line event pulser
`ifndef CIOLEP_DEFINES_VH
`define CIOLEP_DEFINES_VH

// Clock rate and microsecond tick
`define CIOLEP_CLK_HZ      40000000
`define CIOLEP_TICK_US     1
`define CIOLEP_TICK_CYC    ((`CIOLEP_CLK_HZ / 1000000) * `CIOLEP_TICK_US)

// Width of every time setting, in bits
`define CIOLEP_TW          16

// Register byte offsets
`define CIOLEP_OFF_SEL     8'h00
`define CIOLEP_OFF_CFG     8'h04
`define CIOLEP_OFF_DUR     8'h08
`define CIOLEP_OFF_DLY     8'h0C
`define CIOLEP_OFF_PRE     8'h10
`define CIOLEP_OFF_DEB     8'h14
`define CIOLEP_OFF_SWTRIG  8'h18
`define CIOLEP_OFF_STAT    8'h1C

// Line configuration fields
`define CIOLEP_CFG_INV     0
`define CIOLEP_CFG_EN      1
`define CIOLEP_CFG_MODE    2
`define CIOLEP_CFG_SRC_LO  4
`define CIOLEP_CFG_SRC_HI  7

// Reset values
`define CIOLEP_RST_INV     1'b0
`define CIOLEP_RST_EN      1'b0
`define CIOLEP_RST_MODE    1'b0
`define CIOLEP_RST_SRC     4'h0
`define CIOLEP_RST_TIME    16'h0000

// Event source choices
`define CIOLEP_SRC_EXPO    4'h1
`define CIOLEP_SRC_ACQS    4'h2
`define CIOLEP_SRC_ACQP    4'h3
`define CIOLEP_SRC_BRSS    4'h4
`define CIOLEP_SRC_BRSE    4'h5
`define CIOLEP_SRC_SOFT    4'h6
`define CIOLEP_SRC_HARD    4'h7
`define CIOLEP_SRC_CNT     4'h8
`define CIOLEP_SRC_TMR     4'h9
`define CIOLEP_SRC_WAIT    4'hA

// Pulse engine states
`define CIOLEP_ST_IDLE     2'h0
`define CIOLEP_ST_DLY      2'h1
`define CIOLEP_ST_ACT      2'h2

`endif

// ===== ciolep_debounce.v
// Input debouncer counting stable microsecond ticks
`include "ciolep_defines.vh"

module ciolep_debounce #(
  parameter TW = `CIOLEP_TW
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          nrst_i,
  // Timing
  input  wire          tick_i,
  input  wire [TW-1:0] limit_i,
  // Data
  input  wire          din_i,
  output reg           q_o
);

  reg [TW-1:0] cnt_r;

  // Accept a new level only after it stays put for limit ticks
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= {TW{1'b0}};
      q_o   <= 1'b0;
    end else if (din_i == q_o) begin
      cnt_r <= {TW{1'b0}};          // Any bounce restarts the count
    end else if (cnt_r >= limit_i) begin
      q_o   <= din_i;               // R1
      cnt_r <= {TW{1'b0}};
    end else if (tick_i) begin
      cnt_r <= cnt_r + {{(TW-1){1'b0}}, 1'b1};
    end
  end

endmodule // ciolep_debounce

// ===== ciolep_top.v
// Camera I/O line logic: debounce, event pulses, Avalon-MM registers
//
// Notes on behaviour
// R1: Debounce trigger input over programmable interval
// R2: Isolated line, bidirectional line, selector picks
// R3: Bidirectional line drives only in pulse mode
// R4: Inversion drives complement of normal level
// R5: Inversion off on every line after reset
// R6: Enabled line pulses on chosen event
// R7: Choices 1-3: exposure, acquisition start, stop
// R8: Choices 4-5: burst begin and end
// R9: Choices 6-7: software and hardware trigger
// R10: Choices 8-9: counter and timer output
// R11: Choice 10: camera trigger response signal
// R12: Line trigger command fires one timer pulse
// R13: Width zero follows exposure, else programmed
// R14: Delay pulse after exposure start
// R15: Lead time asserts pulse before exposure
// R16: Idle level when disabled or not output
// R17: Times counted in microsecond ticks
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`include "ciolep_defines.vh"

module ciolep_top #(
  parameter TW       = `CIOLEP_TW,
  parameter TICK_CYC = `CIOLEP_TICK_CYC
) (
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        NRST_I,
  // Avalon-MM slave
  input  wire [7:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output reg  [31:0] AVS_READDATA_O,
  output reg         AVS_WAITREQUEST_O,
  // Camera events, one-cycle pulses; EXPO_ACTIVE_I is a level
  input  wire        EXPO_REQ_I,
  input  wire        EXPO_START_I,
  input  wire        EXPO_ACTIVE_I,
  input  wire        ACQ_START_I,
  input  wire        ACQ_STOP_I,
  input  wire        BURST_START_I,
  input  wire        BURST_END_I,
  input  wire        SOFT_TRIG_I,
  input  wire        HARD_TRIG_I,
  input  wire        COUNT_OUT_I,
  input  wire        TRIG_WAIT_I,
  // Exposure go after lead time
  output reg         EXPO_GO_O,
  // Lines
  input  wire        LINE0_I,
  input  wire        LINE2_I,
  output wire        LINE1_O,
  output wire        LINE2_O,
  output reg         LINE2_OE_O,
  output wire        LINE0_DB_O,
  output wire        LINE2_DB_O
);

  localparam [5:0] TICK_MAX = TICK_CYC[5:0] - 6'h01;

  // Register storage; bit 0 is line 1, bit 1 is line 2
  reg          sel_r, mode2_r, tick_r, lead_r;
  reg [1:0]    inv_r, en_r, swt_r;
  reg [7:0]    src_r;
  reg [TW-1:0] dur_r, dly_r, pre_r, deb_r;
  reg [5:0]    div_r;
  reg [TW-1:0] lead_cnt_r;
  wire [1:0]   act_w, line_w, out_ok;
  wire         acc, do_wr, lead_start;

  // Microsecond tick from the system clock
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      div_r  <= 6'h00;
      tick_r <= 1'b0;
    end else if (div_r == TICK_MAX) begin
      div_r  <= 6'h00;
      tick_r <= 1'b1;              // R17
    end else begin
      div_r  <= div_r + 6'h01;
      tick_r <= 1'b0;
    end
  end

  // Debounce both inputs with the same interval
  ciolep_debounce #(.TW(TW)) u_deb0 (
    .clk_i   (CLK_SYS_I),
    .nrst_i  (NRST_I),
    .tick_i  (tick_r),
    .limit_i (deb_r),
    .din_i   (LINE0_I),
    .q_o     (LINE0_DB_O)
  );

  ciolep_debounce #(.TW(TW)) u_deb2 (
    .clk_i   (CLK_SYS_I),
    .nrst_i  (NRST_I),
    .tick_i  (tick_r),
    .limit_i (deb_r),
    .din_i   (LINE2_I),
    .q_o     (LINE2_DB_O)
  );

  // Bus handshake: one wait cycle, then the access completes
  assign acc   = AVS_READ_I | AVS_WRITE_I;
  assign do_wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O;

  // Byte-lane merge for 16-bit time registers
  function [TW-1:0] merge;
    input [TW-1:0] old;
    input [31:0]   wd;
    input [3:0]    be;
    begin
      merge = old;
      if (be[0])
        merge[7:0] = wd[7:0];
      if (be[1])
        merge[TW-1:8] = wd[TW-1:8];
    end
  endfunction

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else if (acc & AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  // Read data captured as waitrequest drops; unmapped reads zero
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else if (AVS_READ_I & AVS_WAITREQUEST_O) begin
      AVS_READDATA_O <= 32'h00000000;
      case (AVS_ADDRESS_I)
        `CIOLEP_OFF_SEL:
          AVS_READDATA_O[0] <= sel_r;
        `CIOLEP_OFF_CFG: begin
          AVS_READDATA_O[`CIOLEP_CFG_INV]  <= inv_r[sel_r];
          AVS_READDATA_O[`CIOLEP_CFG_EN]   <= en_r[sel_r];
          AVS_READDATA_O[`CIOLEP_CFG_MODE] <= out_ok[sel_r];
          AVS_READDATA_O[`CIOLEP_CFG_SRC_HI:`CIOLEP_CFG_SRC_LO] <=
            sel_r ? src_r[7:4] : src_r[3:0];
        end
        `CIOLEP_OFF_DUR: AVS_READDATA_O[TW-1:0] <= dur_r;
        `CIOLEP_OFF_DLY: AVS_READDATA_O[TW-1:0] <= dly_r;
        `CIOLEP_OFF_PRE: AVS_READDATA_O[TW-1:0] <= pre_r;
        `CIOLEP_OFF_DEB: AVS_READDATA_O[TW-1:0] <= deb_r;
        `CIOLEP_OFF_STAT:
          AVS_READDATA_O[6:0] <= {lead_r, act_w, LINE2_DB_O,
                                  LINE0_DB_O, line_w};
        default: AVS_READDATA_O <= 32'h00000000;
      endcase
    end
  end

  // Register writes, per-line fields banked by the selector
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sel_r   <= 1'b0;
      inv_r   <= {2{`CIOLEP_RST_INV}};           // R5
      en_r    <= {2{`CIOLEP_RST_EN}};
      mode2_r <= `CIOLEP_RST_MODE;
      src_r   <= {2{`CIOLEP_RST_SRC}};
      dur_r   <= `CIOLEP_RST_TIME;
      dly_r   <= `CIOLEP_RST_TIME;
      pre_r   <= `CIOLEP_RST_TIME;
      deb_r   <= `CIOLEP_RST_TIME;
      swt_r   <= 2'h0;
    end else begin
      swt_r <= 2'h0;
      if (do_wr) begin
        case (AVS_ADDRESS_I)
          `CIOLEP_OFF_SEL:
            if (AVS_BYTEENABLE_I[0])
              sel_r <= AVS_WRITEDATA_I[0];          // R2
          `CIOLEP_OFF_CFG:
            if (AVS_BYTEENABLE_I[0]) begin
              inv_r[sel_r] <= AVS_WRITEDATA_I[`CIOLEP_CFG_INV];
              en_r[sel_r]  <= AVS_WRITEDATA_I[`CIOLEP_CFG_EN];
              if (sel_r) begin
                mode2_r    <= AVS_WRITEDATA_I[`CIOLEP_CFG_MODE];
                src_r[7:4] <= AVS_WRITEDATA_I[7:4];
              end else
                src_r[3:0] <= AVS_WRITEDATA_I[7:4];
            end
          `CIOLEP_OFF_DUR:
            dur_r <= merge(dur_r, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `CIOLEP_OFF_DLY:
            dly_r <= merge(dly_r, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `CIOLEP_OFF_PRE:
            pre_r <= merge(pre_r, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `CIOLEP_OFF_DEB:
            deb_r <= merge(deb_r, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          `CIOLEP_OFF_SWTRIG:
            if (AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[0])
              swt_r[sel_r] <= 1'b1;                 // R12
          default: ;
        endcase
      end
    end
  end

  // Line 1 is always an output; line 2 only in pulse mode
  assign out_ok = {mode2_r, 1'b1};

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I)
      LINE2_OE_O <= 1'b0;
    else
      LINE2_OE_O <= mode2_r;                        // R3
  end

  // Lead timer: requests during a running lead are ignored
  assign lead_start = EXPO_REQ_I & ~lead_r & (pre_r != `CIOLEP_RST_TIME);

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lead_r     <= 1'b0;
      lead_cnt_r <= {TW{1'b0}};
      EXPO_GO_O  <= 1'b0;
    end else begin
      EXPO_GO_O <= 1'b0;
      if (lead_start) begin
        lead_r     <= 1'b1;                         // R15
        lead_cnt_r <= pre_r;
      end else if (EXPO_REQ_I & ~lead_r) begin
        EXPO_GO_O <= 1'b1;
      end else if (lead_r & tick_r) begin
        if (lead_cnt_r <= {{(TW-1){1'b0}}, 1'b1}) begin
          lead_r    <= 1'b0;
          EXPO_GO_O <= 1'b1;
        end else begin
          lead_cnt_r <= lead_cnt_r - {{(TW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign LINE1_O = line_w[0];
  assign LINE2_O = line_w[1];

  // One pulse engine per output line
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      reg  [1:0]    st_r;
      reg  [TW-1:0] cnt_r;
      reg           saw_r;
      reg           out_r;
      reg           ev;
      wire [3:0]    src = src_r[4*g+3:4*g];
      wire          use_lead = (src == `CIOLEP_SRC_EXPO) &
                               (pre_r != `CIOLEP_RST_TIME);
      wire          ok = en_r[g] & out_ok[g];
      wire          cnt_end = cnt_r <= {{(TW-1){1'b0}}, 1'b1};

      // Event source choice
      always @* begin
        case (src)
          `CIOLEP_SRC_EXPO:
            ev = use_lead ? lead_start : EXPO_START_I;  // R7
          `CIOLEP_SRC_ACQS: ev = ACQ_START_I;           // R7
          `CIOLEP_SRC_ACQP: ev = ACQ_STOP_I;            // R7
          `CIOLEP_SRC_BRSS: ev = BURST_START_I;         // R8
          `CIOLEP_SRC_BRSE: ev = BURST_END_I;           // R8
          `CIOLEP_SRC_SOFT: ev = SOFT_TRIG_I;           // R9
          `CIOLEP_SRC_HARD: ev = HARD_TRIG_I;           // R9
          `CIOLEP_SRC_CNT:  ev = COUNT_OUT_I;           // R10
          `CIOLEP_SRC_TMR:  ev = swt_r[g];              // R10 R12
          `CIOLEP_SRC_WAIT: ev = TRIG_WAIT_I;           // R11
          default:          ev = 1'b0;
        endcase
      end

      // Delay then width; width zero waits for exposure to end
      always @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
          st_r  <= `CIOLEP_ST_IDLE;
          cnt_r <= {TW{1'b0}};
          saw_r <= 1'b0;
        end else begin
          case (st_r)
            `CIOLEP_ST_IDLE:
              if (ok & ev) begin                        // R6
                saw_r <= 1'b0;
                if (use_lead | (dly_r == `CIOLEP_RST_TIME)) begin
                  st_r  <= `CIOLEP_ST_ACT;
                  cnt_r <= dur_r;
                end else begin
                  st_r  <= `CIOLEP_ST_DLY;             // R14
                  cnt_r <= dly_r;
                end
              end
            `CIOLEP_ST_DLY:
              if (!ok)
                st_r <= `CIOLEP_ST_IDLE;
              else if (tick_r & cnt_end) begin
                st_r  <= `CIOLEP_ST_ACT;               // R14
                cnt_r <= dur_r;
              end else if (tick_r)
                cnt_r <= cnt_r - {{(TW-1){1'b0}}, 1'b1};
            `CIOLEP_ST_ACT:
              if (!ok)
                st_r <= `CIOLEP_ST_IDLE;               // R16
              else if (cnt_r == {TW{1'b0}}) begin
                if (EXPO_ACTIVE_I)
                  saw_r <= 1'b1;                       // R13
                else if (saw_r)
                  st_r <= `CIOLEP_ST_IDLE;             // R13
              end else if (tick_r & cnt_end)
                st_r <= `CIOLEP_ST_IDLE;               // R13
              else if (tick_r)
                cnt_r <= cnt_r - {{(TW-1){1'b0}}, 1'b1};
            default: st_r <= `CIOLEP_ST_IDLE;
          endcase
        end
      end

      // Registered pin level; inversion also moves the idle level
      always @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I)
          out_r <= 1'b0;
        else
          out_r <= (st_r == `CIOLEP_ST_ACT) ^ inv_r[g];  // R4 R16
      end

      assign act_w[g]  = (st_r == `CIOLEP_ST_ACT);
      assign line_w[g] = out_r;
    end
  endgenerate

endmodule // ciolep_top

// ===== ciolep_checker.sv
// Port checks for the camera line pulser
`include "ciolep_defines.vh"
module ciolep_checker (
  // Clock and reset
  input wire        CLK_SYS_I,
  input wire        NRST_I,
  // Register bus
  input wire [7:0]  AVS_ADDRESS_I,
  input wire        AVS_READ_I,
  input wire        AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0]  AVS_BYTEENABLE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire        AVS_WAITREQUEST_O,
  // Exposure and lines
  input wire        EXPO_REQ_I,
  input wire        EXPO_GO_O,
  input wire        LINE1_O,
  input wire        LINE2_OE_O
);
  logic        sel_r, en1_r, inv1_r, mode2_r;
  logic [15:0] lead_r;
  // Completed writes; only lane 0 is tracked, lead assumes full lanes
  wire         wdone = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire         lane0 = wdone && AVS_BYTEENABLE_I[0];
  wire         cfg_w = lane0 && AVS_ADDRESS_I == `CIOLEP_OFF_CFG;

  // Shadow of the settings that the checks lean on
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      {sel_r, en1_r, inv1_r, mode2_r, lead_r} <= 20'h00000;
    end else begin
      if (lane0 && AVS_ADDRESS_I == `CIOLEP_OFF_SEL)
        sel_r <= AVS_WRITEDATA_I[0];
      if (cfg_w && !sel_r)
        {en1_r, inv1_r} <= AVS_WRITEDATA_I[1:0];
      if (cfg_w && sel_r)
        mode2_r <= AVS_WRITEDATA_I[`CIOLEP_CFG_MODE];
      if (lane0 && AVS_ADDRESS_I == `CIOLEP_OFF_PRE)
        lead_r <= AVS_WRITEDATA_I[15:0];
    end
  end

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // Bus answers once, one cycle after taking a request
  a_wait_answer: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus request left unanswered");
  a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  a_wait_cause: assert property ($fell(AVS_WAITREQUEST_O) |->
    $past(AVS_READ_I) || $past(AVS_WRITE_I))
    else $error("answer without request");
  a_unmapped_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O &&
    AVS_ADDRESS_I > `CIOLEP_OFF_STAT |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");
  // Line 2 drives only in pulse-output mode
  a_oe_mode: assert property (!mode2_r [*2] |-> !LINE2_OE_O)
    else $error("line 2 driven outside pulse mode");
  // A disabled line rests at its idle level after inversion
  a_idle_level: assert property (
    (!en1_r && $stable(inv1_r)) [*3] |-> LINE1_O == inv1_r)
    else $error("line 1 not at idle level");
  // Without lead the exposure go follows the request at once
  a_go_quick: assert property (
    EXPO_REQ_I && lead_r == 16'h0000 |=> EXPO_GO_O)
    else $error("exposure go late");
  a_go_pulse: assert property (EXPO_GO_O |=> !EXPO_GO_O)
    else $error("exposure go too long");
endmodule // ciolep_checker

bind ciolep_top ciolep_checker u_chk (.CLK_SYS_I, .NRST_I, .AVS_ADDRESS_I,
  .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .EXPO_REQ_I, .EXPO_GO_O, .LINE1_O,
  .LINE2_OE_O);

// ===== ciolep_partner.sv
// External trigger switch and line 2 load
module ciolep_partner (
  // Clock
  input  wire  clk_i,
  // Levels the far side presents
  input  wire  trig_lvl_i,
  input  wire  line2_lvl_i,
  // Line 2 as the camera drives it
  input  wire  cam_line2_i,
  input  wire  cam_oe_i,
  // Pins into the camera
  output wire  trig_pin_o,
  output wire  line2_pin_o
);
  logic last  = 1'h0;
  logic pin_r = 1'h0;
  int   bnc   = 0;
  // One driver for the switch pin
  assign trig_pin_o = pin_r;
  // Contacts chatter for five cycles after each change
  always @(posedge clk_i) begin
    last  <= trig_lvl_i;
    bnc   <= (trig_lvl_i != last) ? 5 : (bnc > 0 ? bnc - 1 : 0);
    pin_r <= (bnc > 0) ? 1'($urandom) : trig_lvl_i;
  end
  // The camera owns the wire while it drives, else the load does
  assign line2_pin_o = cam_oe_i ? cam_line2_i : line2_lvl_i;
endmodule // ciolep_partner

// ===== ciolep_tb.sv
// Self-checking bench for the camera I/O line pulser
`include "ciolep_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4; // Short tick keeps the run brief
  logic        clk  = 1'h0;
  logic        nrst = 1'h0;
  logic        rd   = 1'h0;
  logic        wr   = 1'h0;
  logic [7:0]  adr  = 8'h00;
  logic [31:0] wd   = 32'h0;
  logic [3:0]  be   = 4'hF;
  logic [9:0]  ev   = 10'h000;
  logic        req  = 1'h0;
  logic        act  = 1'h0;
  logic        trig = 1'h0;
  logic        lvl2 = 1'h0;
  logic        sel  = 1'h0;
  wire  [31:0] rdat;
  wire         wreq, go, l0, l2, l1o, l2o, l2oe, db0, db2;
  wire         pin  = sel ? l2o : l1o;
  int          miscompares = 0;
  int          total_checks = 0;

  always #12.5 clk = ~clk;
  // Device and far side
  ciolep_top #(.TICK_CYC(T)) DUT (
    .CLK_SYS_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .EXPO_REQ_I(req), .EXPO_START_I(ev[0]),
    .EXPO_ACTIVE_I(act), .ACQ_START_I(ev[1]), .ACQ_STOP_I(ev[2]),
    .BURST_START_I(ev[3]), .BURST_END_I(ev[4]), .SOFT_TRIG_I(ev[5]),
    .HARD_TRIG_I(ev[6]), .COUNT_OUT_I(ev[7]), .TRIG_WAIT_I(ev[9]),
    .EXPO_GO_O(go), .LINE0_I(l0), .LINE2_I(l2), .LINE1_O(l1o),
    .LINE2_O(l2o), .LINE2_OE_O(l2oe), .LINE0_DB_O(db0),
    .LINE2_DB_O(db2));
  ciolep_partner u_far (.clk_i(clk), .trig_lvl_i(trig), .line2_lvl_i(lvl2),
    .cam_line2_i(l2o), .cam_oe_i(l2oe), .trig_pin_o(l0), .line2_pin_o(l2));

  // Compares; a mismatch is reported at once
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %h, want %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic rng(input int n, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("wrong value at %0t: %0d cycles not in %0d..%0d",
               $time, n, lo, hi);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wd  <= d;
    be  <= b;
    rd  <= !w;
    wr  <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'h0 && n < 20);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
    if (n >= 20) begin
      miscompares++;
      $display("wrong value at %0t: bus request unanswered", $time);
    end
  endtask
  // Reset value of a register: only the line 1 mode bit reads one
  function automatic logic [31:0] exp_rst(input logic [7:0] a);
    return (a == `CIOLEP_OFF_CFG) ? 32'h4 : 32'h0;
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, 4'hF, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask
  // Select a line, set it up and let the idle level settle
  task automatic cfg(input logic ln, iv, en, md, input logic [3:0] src);
    sel = ln;
    wreg(`CIOLEP_OFF_SEL, {31'h0, ln});
    wreg(`CIOLEP_OFF_CFG, {24'h0, src, 1'h0, md, en, iv});
    repeat (4) @(posedge clk);
  endtask
  // Raise the camera event behind a source choice
  task automatic fire(input int s);
    if (s == 9)
      wreg(`CIOLEP_OFF_SWTRIG, 32'h1);
    else begin
      ev <= 10'h1 << (s - 1);
      @(posedge clk);
      ev <= 10'h000;
    end
  endtask
  // Cycles the watched pin stays at v, capped
  task automatic hold(input logic v, output int n);
    n = 0;
    while (pin === v && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #500000;
    miscompares++;
    wrap_up;
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic        iv;
    int          d, w, n;
    void'($urandom(32'hEBCA));
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    for (int a = 0; a <= 32; a += 4)
      rchk(8'(a), exp_rst(8'(a)));
    wreg(8'h20, 32'hFFFFFFFF);
    rchk(8'h20, 32'h0);
    bus(1'h1, `CIOLEP_OFF_DUR, 32'hFF, 4'h0, q);
    rchk(`CIOLEP_OFF_DUR, 32'h0);
    // Each source, after every other event but the line trigger command has fired
    wreg(`CIOLEP_OFF_DUR, 32'h2);
    for (int s = 0; s < 12; s++) begin
      iv = 1'($urandom);
      cfg(1'h0, iv, 1'h1, 1'h0, 4'(s));
      ev <= (s > 0 && s < 11) ? ~(10'h1 << (s - 1)) : 10'h3FF;
      @(posedge clk);
      ev <= 10'h000;
      repeat (12) @(posedge clk);
      chkb(pin, iv);
      if (s > 0 && s < 11) begin
        fire(s);
        hold(iv, d);
        hold(!iv, w);
        rng(d, 0, 6);
        rng(w, T, 2 * T + 2);
      end
    end
    // Disabled line 1, line 2 outside pulse mode, then inverted pulse
    cfg(1'h0, 1'h1, 1'h0, 1'h0, 4'h2);
    cfg(1'h1, 1'h0, 1'h1, 1'h0, 4'h2);
    fire(2);
    repeat (8) @(posedge clk);
    chkb(l1o, 1'h1);
    chkb(l2oe, 1'h0);
    cfg(1'h1, 1'h1, 1'h1, 1'h1, 4'h2);
    fire(2);
    hold(1'h1, d);
    hold(1'h0, w);
    rng(w, T, 2 * T + 2);
    chkb(l2oe, 1'h1);
    // Zero width follows the exposure
    wreg(`CIOLEP_OFF_DUR, 32'h0);
    cfg(1'h0, 1'h0, 1'h1, 1'h0, 4'h1);
    ev  <= 10'h001;
    act <= 1'h1;
    @(posedge clk);
    ev <= 10'h000;
    repeat (20) @(posedge clk);
    chkb(l1o, 1'h1);
    act <= 1'h0;
    hold(1'h1, w);
    rng(w, 0, 4);
    // Delay after exposure start, then lead time
    wreg(`CIOLEP_OFF_DUR, 32'h2);
    wreg(`CIOLEP_OFF_DLY, 32'h3);
    fire(1);
    hold(1'h0, d);
    rng(d, 2 * T, 3 * T + 3);
    hold(1'h1, w);
    wreg(`CIOLEP_OFF_DLY, 32'h0);
    wreg(`CIOLEP_OFF_PRE, 32'h5);
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    hold(1'h0, d);
    n = d;
    while (go !== 1'h1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    rng(d, 0, 4);
    rng(n, 4 * T, 5 * T + 3);
    wreg(`CIOLEP_OFF_PRE, 32'h0);
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    @(posedge clk);
    chkb(go, 1'h1);
    // Chatter shorter than the interval is dropped
    wreg(`CIOLEP_OFF_DEB, 32'h5);
    trig <= 1'h1;
    repeat (3) @(posedge clk);
    trig <= 1'h0;
    repeat (40) @(posedge clk);
    chkb(db0, 1'h0);
    trig <= 1'h1;
    n = 0;
    while (db0 !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    rng(n, 4 * T - 1, 5 * T + 10);
    bus(1'h0, `CIOLEP_OFF_STAT, 32'h0, 4'hF, q);
    chk(q & 32'h4, 32'h4);
    // Released line 2 reads the far side
    chkb(db2, 1'h1);
    cfg(1'h1, 1'h0, 1'h0, 1'h0, 4'h0);
    repeat (40) @(posedge clk);
    chkb(db2, 1'h0);
    wrap_up;
  end
endmodule // testbench
